// ==== rtl/stc_pkg.sv ====
// package: constants and types of the transmit input clocking block
`default_nettype none
package stc_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    // control field positions
    localparam int CTRL_CLK_SEL = 0;
    localparam int CTRL_RATE_SEL = 1;
    localparam int CTRL_RATIO_SEL = 2;
    localparam int CTRL_FIFO_HOLD = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    // status field positions
    localparam int STAT_LOCKED = 0;
    localparam int STAT_ALIGNED = 1;
    localparam int STAT_OVERFLOW = 3;
    localparam int STAT_UNDERFLOW = 5;
    // channels and fifo shape
    localparam int NUM_CHAN = 2;
    localparam int FIFO_DEPTH = 8;
    localparam int PTR_W = 4;
    localparam logic [PTR_W-1:0] FIFO_HALF = 4'h4;
    localparam logic [PTR_W-1:0] FIFO_FULL = 4'h8;
    // serial bits per word and reference multipliers
    localparam logic [4:0] BITS_PER_WORD = 5'h0A;
    localparam logic [4:0] WCLK_HIGH_BITS = 5'h05;
    localparam logic [4:0] REF_MULT_LO = 5'h0A;
    localparam logic [4:0] REF_MULT_HI = 5'h14;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int DRIFT_NS = 3;
    localparam int DRIFT_CYC = (DRIFT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [6:0] INIT_CYC = 7'h40;
    // one parallel input word
    typedef struct packed {
        logic sync_char_request;
        logic control_char_request;
        logic [7:0] data;
    } stc_word_s;
endpackage
`default_nettype wire

// ==== rtl/stc_chan_fifo.sv ====
// per-channel holding register and dual-clock input fifo
`default_nettype none
module stc_chan_fifo
    import stc_pkg::*;
(
    input wire logic link_clk,
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic init_req,
    input wire stc_word_s word_in,
    input wire logic rd_en,
    output stc_word_s rd_word,
    output logic [PTR_W-1:0] level
);

    function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
        logic [PTR_W-1:0] b;
        b = '0;
        for (int i = PTR_W - 1; i >= 0; i--)
        begin
            b[i] = g[i] ^ ((i == PTR_W - 1) ? 1'b0 : b[i + 1]);
        end
        return b;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic init_s1_ff;
    logic init_s2_ff;
    stc_word_s hold_ff;
    logic [PTR_W-1:0] wbin_ff;
    logic [PTR_W-1:0] wgray_ff;
    logic [PTR_W-1:0] nxt_wbin;
    stc_word_s mem [FIFO_DEPTH];

    always_ff @(posedge link_clk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            init_s1_ff <= 1'b1;
            init_s2_ff <= 1'b1;
        end
        else
        begin
            init_s1_ff <= init_req;
            init_s2_ff <= init_s1_ff;
        end
    end

    always_ff @(posedge link_clk or negedge hresetn)
    begin
        if (!hresetn)
            hold_ff <= '0;
        else
            hold_ff <= word_in;
    end

    assign nxt_wbin = init_s2_ff ? '0 : wbin_ff + 4'h1;

    always_ff @(posedge link_clk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wbin_ff <= '0;
            wgray_ff <= '0;
        end
        else
        begin
            wbin_ff <= nxt_wbin;
            wgray_ff <= nxt_wbin ^ (nxt_wbin >> 1);
        end
    end

    always_ff @(posedge link_clk)
    begin
        if (!init_s2_ff)
            mem[wbin_ff[PTR_W-2:0]] <= hold_ff;
    end

    ////////////////////////////////////////////////////////////////////////////
    // gray pointer resync to hclk
    logic [PTR_W-1:0] wg_s1_ff;
    logic [PTR_W-1:0] wg_s2_ff;
    logic [PTR_W-1:0] rbin_ff;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wg_s1_ff <= '0;
            wg_s2_ff <= '0;
        end
        else
        begin
            wg_s1_ff <= wgray_ff;
            wg_s2_ff <= wg_s1_ff;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rbin_ff <= '0;
        else if (init_req)
            rbin_ff <= '0;
        else if (rd_en)
            rbin_ff <= rbin_ff + 4'h1;
    end

    assign level = gray2bin(wg_s2_ff) - rbin_ff;
    assign rd_word = mem[rbin_ff[PTR_W-2:0]];

endmodule
`default_nettype wire

// ==== rtl/stc_tx_input_clocking.sv ====
// transmit input clocking: word clock, rate selection, input capture and fifos
//
// Implementation choices: register access over AHB-Lite and the address map.
`default_nettype none
module stc_tx_input_clocking
    import stc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic pll_locked,
    input wire logic channel_data_clock_0,
    input wire logic channel_data_clock_1,
    input wire stc_word_s [NUM_CHAN-1:0] word_in,
    output logic word_rate_clock_out,
    output logic serial_bit_tick,
    output logic [4:0] pll_multiplier,
    output stc_word_s [NUM_CHAN-1:0] tx_word,
    output logic [NUM_CHAN-1:0] tx_word_valid
);

    ////////////////////////////////////////////////////////////////////////////
    // register bus
    logic [3:0] ctrl_ff;
    logic [6:0] status_ff;
    logic [31:0] hrdata_ff;
    logic wr_pend_ff;
    logic [7:0] wr_addr_ff;
    logic addr_phase;
    logic wr_ctrl;
    logic wr_status;
    logic input_clock_select;
    logic rate_select;
    logic reference_ratio_select;
    logic fifo_hold;

    assign addr_phase = hsel & hready & htrans[1];
    assign wr_ctrl = wr_pend_ff & (wr_addr_ff == ADDR_CTRL);
    assign wr_status = wr_pend_ff & (wr_addr_ff == ADDR_STATUS);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= '0;
        end
        else
        begin
            wr_pend_ff <= addr_phase & hwrite;
            wr_addr_ff <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_ff <= '0;
        else if (addr_phase & !hwrite)
        begin
            if (haddr[7:0] == ADDR_CTRL)
                hrdata_ff <= {28'h0, ctrl_ff};
            else if (haddr[7:0] == ADDR_STATUS)
                hrdata_ff <= {25'h0, status_ff};
            else
                hrdata_ff <= '0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ctrl_ff <= CTRL_RESET;
        else if (wr_ctrl)
            ctrl_ff <= hwdata[3:0];
    end

    assign input_clock_select = ctrl_ff[CTRL_CLK_SEL];
    assign rate_select = ctrl_ff[CTRL_RATE_SEL];
    assign reference_ratio_select = ctrl_ff[CTRL_RATIO_SEL];
    assign fifo_hold = ctrl_ff[CTRL_FIFO_HOLD];

    ////////////////////////////////////////////////////////////////////////////
    // shared bit and word clock generation
    logic half_ff;
    logic [4:0] bit_cnt_ff;
    logic word_clk_ff;
    logic word_tick;
    logic [4:0] mult_ff;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            half_ff <= 1'b0;
        else
            half_ff <= ~half_ff;
    end

    // bit every vco cycle at full rate
    assign serial_bit_tick = ~rate_select | half_ff;
    assign word_tick = serial_bit_tick & (bit_cnt_ff == BITS_PER_WORD - 5'h01);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            bit_cnt_ff <= '0;
        else if (word_tick)
            bit_cnt_ff <= '0;
        else if (serial_bit_tick)
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            word_clk_ff <= 1'b0;
        else
            word_clk_ff <= (word_tick | bit_cnt_ff < WCLK_HIGH_BITS - 5'h01) & ~(
                serial_bit_tick & bit_cnt_ff == WCLK_HIGH_BITS - 5'h01);
    end
    assign word_rate_clock_out = word_clk_ff;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            mult_ff <= REF_MULT_LO;
        else
            mult_ff <= reference_ratio_select ? REF_MULT_HI : REF_MULT_LO;
    end
    assign pll_multiplier = mult_ff;

    ////////////////////////////////////////////////////////////////////////////
    // fifo initialisation
    logic lock_s1_ff;
    logic lock_s2_ff;
    logic lock_d_ff;
    logic [6:0] init_cnt_ff;
    logic init_req;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            lock_s1_ff <= 1'b0;
            lock_s2_ff <= 1'b0;
            lock_d_ff <= 1'b0;
        end
        else
        begin
            lock_s1_ff <= pll_locked;
            lock_s2_ff <= lock_s1_ff;
            lock_d_ff <= lock_s2_ff;
        end
    end

    // init on lock rise or while hold bit set
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            init_cnt_ff <= '0;
        else if (fifo_hold | (lock_s2_ff & ~lock_d_ff))
            init_cnt_ff <= INIT_CYC;
        else if (init_cnt_ff != 7'h00)
            init_cnt_ff <= init_cnt_ff - 7'h01;
    end
    assign init_req = (init_cnt_ff != 7'h00);

    ////////////////////////////////////////////////////////////////////////////
    // channels
    logic [NUM_CHAN-1:0] link_clk;
    logic [NUM_CHAN-1:0] aligned_ff;
    logic [NUM_CHAN-1:0] rd_en;
    logic [NUM_CHAN-1:0] ovf_set;
    logic [NUM_CHAN-1:0] unf_set;
    logic [PTR_W-1:0] level [NUM_CHAN];
    stc_word_s rd_word [NUM_CHAN];
    stc_word_s ref_s1_ff [NUM_CHAN];
    stc_word_s ref_s2_ff [NUM_CHAN];

    assign link_clk = {channel_data_clock_1, channel_data_clock_0};

    // one fifo and clock per channel
    for (genvar c = 0; c < NUM_CHAN; c++)
    begin : g_chan
        stc_chan_fifo u_fifo (
            .link_clk(link_clk[c]),
            .hclk(hclk),
            .hresetn(hresetn),
            .init_req(init_req),
            .word_in(word_in[c]),
            .rd_en(rd_en[c]),
            .rd_word(rd_word[c]),
            .level(level[c])
        );

        // reference mode capture on word clock
        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
            begin
                ref_s1_ff[c] <= '0;
                ref_s2_ff[c] <= '0;
            end
            else
            begin
                ref_s1_ff[c] <= word_in[c];
                ref_s2_ff[c] <= ref_s1_ff[c];
            end
        end

        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
                aligned_ff[c] <= 1'b0;
            else if (init_req)
                aligned_ff[c] <= 1'b0;
            else if (level[c] >= FIFO_HALF)
                aligned_ff[c] <= 1'b1;
        end

        assign rd_en[c] = input_clock_select & aligned_ff[c] & word_tick & (level[c] != '0);
        assign unf_set[c] = input_clock_select & aligned_ff[c] & word_tick & (level[c] == '0);
        assign ovf_set[c] = input_clock_select & aligned_ff[c] & (level[c] == FIFO_FULL);

        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
            begin
                tx_word[c] <= '0;
                tx_word_valid[c] <= 1'b0;
            end
            else
            begin
                tx_word_valid[c] <= word_tick & (~input_clock_select | rd_en[c]);
                if (word_tick)
                    tx_word[c] <= input_clock_select ? rd_word[c] : ref_s2_ff[c];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status: live lock and aligned bits, sticky fifo flags, write one to clear, set wins
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            status_ff <= '0;
        else
        begin
            status_ff[STAT_LOCKED] <= lock_s2_ff;
            status_ff[STAT_ALIGNED +: NUM_CHAN] <= aligned_ff;
            status_ff[STAT_OVERFLOW +: NUM_CHAN] <= ovf_set | (status_ff[STAT_OVERFLOW +:
                NUM_CHAN] & ~({NUM_CHAN{wr_status}} & hwdata[STAT_OVERFLOW +: NUM_CHAN]));
            status_ff[STAT_UNDERFLOW +: NUM_CHAN] <= unf_set | (status_ff[STAT_UNDERFLOW +:
                NUM_CHAN] & ~({NUM_CHAN{wr_status}} & hwdata[STAT_UNDERFLOW +: NUM_CHAN]));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_quiet_word;
        !word_tick [*8];
    endsequence

    property p_word_spacing;
        word_tick |=> s_quiet_word;
    endproperty
    a_word_spacing: assert property (p_word_spacing)
        else $error("word tick spacing too short");

    property p_full_rate;
        !rate_select && $past(!rate_select) |-> serial_bit_tick;
    endproperty
    a_full_rate: assert property (p_full_rate)
        else $error("missing bit tick at full rate");

    property p_half_rate;
        rate_select && serial_bit_tick |=> rate_select |-> !serial_bit_tick;
    endproperty
    a_half_rate: assert property (p_half_rate)
        else $error("bit tick not halved");

    property p_clock_in_hold;
        fifo_hold |-> ##[1:40] $rose(word_clk_ff);
    endproperty
    a_clock_in_hold: assert property (p_clock_in_hold)
        else $error("word clock stopped during hold");

    property p_word_clk_duty;
        $rose(word_clk_ff) && !rate_select |-> (word_clk_ff [*5] ##1 !word_clk_ff) or
            (##[0:5] rate_select);
    endproperty
    a_word_clk_duty: assert property (p_word_clk_duty)
        else $error("word clock duty wrong");

    property p_align_half;
        $rose(aligned_ff[0]) |-> $past(level[0]) >= FIFO_HALF;
    endproperty
    a_align_half: assert property (p_align_half)
        else $error("aligned before half depth");

    property p_init_clears;
        init_req |=> !aligned_ff[0] && !aligned_ff[1];
    endproperty
    a_init_clears: assert property (p_init_clears)
        else $error("aligned during init");

    property p_lock_init;
        lock_s2_ff && !lock_d_ff |=> init_req [*8];
    endproperty
    a_lock_init: assert property (p_lock_init)
        else $error("no fifo init after lock");

    property p_ref_capture;
        word_tick && !input_clock_select |=> tx_word[0] == $past(ref_s2_ff[0]) && tx_word_valid[0];
    endproperty
    a_ref_capture: assert property (p_ref_capture)
        else $error("reference mode word wrong");

    property p_multiplier;
        ##1 $stable(reference_ratio_select) |-> pll_multiplier == (reference_ratio_select ?
            REF_MULT_HI : REF_MULT_LO);
    endproperty
    a_multiplier: assert property (p_multiplier)
        else $error("multiplier mismatch");

endmodule
`default_nettype wire

// ==== tb/stc_upstream_model.sv ====
// upstream word source that feeds both channels of the transmit input block
`default_nettype none
module stc_upstream_model
    import stc_pkg::*;
(
    input wire logic freeze,
    output logic channel_data_clock_0,
    output logic channel_data_clock_1,
    output stc_word_s [NUM_CHAN-1:0] word_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt0 = 8'h00;
    logic [7:0] cnt1 = 8'h80;
    logic [9:0] w0 = 10'h000;
    logic [9:0] w1 = 10'h200;
    assign word_in[0] = w0;
    assign word_in[1] = w1;
    ////////////////////////////////////////////////////////////////////////////////
    // fixed rate, fixed phase, no drift
    initial
    begin
        channel_data_clock_0 = 1'b0;
        forever #62.5 channel_data_clock_0 = ~channel_data_clock_0;
    end
    initial
    begin
        channel_data_clock_1 = 1'b0;
        #40;
        forever #62.5 channel_data_clock_1 = ~channel_data_clock_1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // data byte with control and sync requests
    always @(posedge channel_data_clock_0)
    begin
        if (!freeze)
        begin
            cnt0 <= cnt0 + 8'h01;
            w0 <= {cnt0[1], cnt0[0], cnt0};
        end
    end
    always @(posedge channel_data_clock_1)
    begin
        if (!freeze)
        begin
            cnt1 <= cnt1 + 8'h01;
            w1 <= {cnt1[1], cnt1[0], cnt1};
        end
    end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// testbench for the transmit input clocking block
`default_nettype none
module tb
    import stc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [31:0] ctrl;
        logic [4:0] mult;
        int cyc;
    } stc_row_s;
    stc_row_s rows [4] = '{
        '{32'h00000000, 5'h0A, 10},
        '{32'h00000002, 5'h0A, 20},
        '{32'h00000004, 5'h14, 10},
        '{32'h00000006, 5'h14, 20}
    };
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, pll_locked, freeze;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic channel_data_clock_0, channel_data_clock_1;
    logic word_rate_clock_out, serial_bit_tick;
    logic [4:0] pll_multiplier;
    stc_word_s [NUM_CHAN-1:0] word_in, tx_word;
    logic [NUM_CHAN-1:0] tx_word_valid;
    int err_total, n_checks, cyc, tk;
    stc_tx_input_clocking u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pll_locked(pll_locked),
        .channel_data_clock_0(channel_data_clock_0),
        .channel_data_clock_1(channel_data_clock_1), .word_in(word_in),
        .word_rate_clock_out(word_rate_clock_out), .serial_bit_tick(serial_bit_tick),
        .pll_multiplier(pll_multiplier), .tx_word(tx_word), .tx_word_valid(tx_word_valid)
    );
    stc_upstream_model u_up (
        .freeze(freeze), .channel_data_clock_0(channel_data_clock_0),
        .channel_data_clock_1(channel_data_clock_1), .word_in(word_in)
    );
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    task automatic wrap_up;
        if (err_total == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic guard(input int i, input int lim);
        if (i >= lim)
        begin
            err_total++;
            $display("unexpected at %0t: wait ran out", $time);
            wrap_up();
        end
    endtask
    task automatic wait_rdy;
        int i;
        @(posedge hclk);
        for (i = 0; i < 20 && hreadyout !== 1'b1; i++)
            @(posedge hclk);
        guard(i, 20);
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h000000, a};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic poll(input logic [31:0] m, input logic [31:0] e, input int lim);
        int i;
        for (i = 0; i < lim; i++)
        begin
            bus(1'b0, ADDR_STATUS, 32'h0);
            if ((rd & m) === e)
                break;
        end
        guard(i, lim);
    endtask
    task automatic wait_valid;
        int i;
        @(negedge hclk);
        for (i = 0; i < 50 && tx_word_valid === 2'h0; i++)
            @(negedge hclk);
        guard(i, 50);
    endtask
    task automatic measure(output int c, output int t);
        int i;
        logic lo;
        c = 0;
        t = 0;
        lo = 1'b0;
        @(negedge hclk);
        for (i = 0; i < 50 && word_rate_clock_out !== 1'b0; i++)
            @(negedge hclk);
        for (i = 0; i < 50 && word_rate_clock_out !== 1'b1; i++)
            @(negedge hclk);
        guard(i, 50);
        while (c < 50 && !(lo && word_rate_clock_out === 1'b1))
        begin
            c++;
            t += (serial_bit_tick === 1'b1) ? 1 : 0;
            lo = lo | (word_rate_clock_out === 1'b0);
            @(negedge hclk);
        end
    endtask
    task automatic watch(input int n);
        logic [7:0] prev [NUM_CHAN];
        int seen [NUM_CHAN];
        int i;
        seen = '{0, 0};
        for (i = 0; i < 400 && seen[0] < n; i++)
        begin
            @(negedge hclk);
            for (int c = 0; c < NUM_CHAN; c++)
            begin
                if (tx_word_valid[c] === 1'b1)
                begin
                    if (seen[c] > 0)
                        check(tx_word[c].data, 8'(prev[c] + 8'h01), "word order");
                    check(tx_word[c][9:8], tx_word[c].data[1:0], "request bits");
                    prev[c] = tx_word[c].data;
                    seen[c]++;
                end
            end
        end
        guard(i, 400);
    endtask
    task automatic do_reset;
        hresetn <= 1'b0;
        repeat (4) @(posedge hclk);
        @(negedge hclk);
        check({hresp, hreadyout, tx_word_valid}, 32'h4, "reset outputs");
        check(pll_multiplier, 32'h0A, "reset multiplier");
        @(posedge hclk);
        hresetn <= 1'b1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        pll_locked = 1'b0;
        freeze = 1'b0;
        err_total = 0;
        n_checks = 0;
        do_reset();
        foreach (rows[r])
        begin
            bus(1'b1, ADDR_CTRL, rows[r].ctrl);
            bus(1'b0, ADDR_CTRL, 32'h0);
            check(rd, rows[r].ctrl, "control readback");
            check(pll_multiplier, rows[r].mult, "multiplier");
            measure(cyc, tk);
            measure(cyc, tk);
            check(cyc, rows[r].cyc, "word clock period");
            check(tk, 10, "bit ticks per word");
        end
        bus(1'b1, 8'h08, 32'hFFFFFFFF);
        bus(1'b0, 8'h08, 32'h0);
        check(rd, 32'h0, "unmapped read");
        bus(1'b0, ADDR_CTRL, 32'h0);
        check(rd, 32'h6, "control kept");
        freeze <= 1'b1;
        bus(1'b1, ADDR_CTRL, 32'h0);
        repeat (3) wait_valid();
        check(tx_word_valid, 32'h3, "both channels tick");
        check(tx_word, word_in, "reference capture");
        freeze <= 1'b0;
        bus(1'b1, ADDR_CTRL, 32'h9);
        pll_locked <= 1'b1;
        poll(32'h1, 32'h1, 10);
        check(rd & 32'h7, 32'h1, "held fifo unaligned");
        measure(cyc, tk);
        check(cyc, 10, "word clock under hold");
        bus(1'b1, ADDR_CTRL, 32'h1);
        bus(1'b0, ADDR_STATUS, 32'h0);
        check(rd & 32'h6, 32'h0, "unaligned in init");
        poll(32'h6, 32'h6, 80);
        check(rd & 32'h6, 32'h6, "aligned after init");
        watch(6);
        poll(32'h60, 32'h60, 150);
        check(rd & 32'h60, 32'h60, "drain flagged");
        bus(1'b1, ADDR_CTRL, 32'h3);
        poll(32'h18, 32'h18, 300);
        check(rd & 32'h18, 32'h18, "fill flagged");
        bus(1'b1, ADDR_STATUS, 32'h60);
        bus(1'b0, ADDR_STATUS, 32'h0);
        check(rd & 32'h60, 32'h0, "drain flag cleared");
        do_reset();
        bus(1'b0, ADDR_CTRL, 32'h0);
        check(rd, 32'(CTRL_RESET), "control after reset");
        wrap_up();
    end
endmodule
`default_nettype wire
